// File: hdl/ipc_top.sv
// Purpose: plug-and-play configuration port with local firmware access
// Assumes: I_HOST_WR and I_LOC_* strobes last one cycle, I_HOST_RD is
//          the host read level, all synchronous to I_CLOCK
// Notes: identity bits come from firmware through the master register
`timescale 1ns/10ps
`default_nettype none
module ipc_top #(
    parameter int CLK_MHZ = 10
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire logic I_CLK_EN,
    input wire logic [11:0] I_HOST_ADDR,
    input wire logic I_HOST_ADDR_QUALIFIER_N,
    input wire logic I_HOST_WR,
    input wire logic I_HOST_RD,
    input wire logic [7:0] I_HOST_DATA,
    output logic [7:0] O_HOST_DATA,
    output logic O_HOST_DATA_OE,
    input wire logic [8:0] I_LOC_ADDR,
    input wire logic I_LOC_WR,
    input wire logic I_LOC_RD,
    input wire logic [7:0] I_LOC_WDATA,
    output logic [7:0] O_LOC_RDATA,
    output logic O_LOC_IRQ,
    output logic [1:0] O_PNP_STATE,
    output logic [7:0] O_ACTIVATE,
    output logic [15:0] O_IO0_BASE,
    output logic [15:0] O_IO1_BASE,
    output logic [7:0] O_IRQ_LEVEL,
    output logic [7:0] O_DMA0,
    output logic [7:0] O_DMA1
);
    typedef struct packed {
        ipc_pkg::ipc_fsm_e fsm;
        logic [7:0] index;
        logic [7:0] rd_addr;
        logic [7:0] card_sel;
        logic [7:0] key_exp;
        logic [4:0] key_cnt;
        logic ie;
        logic ip;
        logic ev_srst;
        logic ev_wake;
        logic ev_iso;
        logic iso_bit;
        logic [7:0] res_data;
        logic res_ready;
        logic [ipc_pkg::CFG_N-1:0][7:0] cfg;
        logic rd_prev;
        logic rd_iso;
        logic iso_second;
        logic [1:0] low_pair;
        logic [7:0] hrdata;
        logic hoe;
        logic [7:0] lrdata;
    } ipc_s;

    ipc_s st;
    ipc_s next_st;

    // the host's own rate limit; the card does not police it
    localparam int ISO_GAP_CYC = ipc_pkg::ISO_GAP_US * CLK_MHZ; // [R22]

    function automatic logic [3:0] cfg_slot(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < ipc_pkg::CFG_N; k++) begin
            if (a == ipc_pkg::CFG_IDX[k]) begin
                r = {1'b1, 3'(k)};
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] state_code(input ipc_pkg::ipc_fsm_e f);
        logic [1:0] c;
        c = ipc_pkg::CODE_WFK;
        case (f)
            ipc_pkg::S_SLP: c = ipc_pkg::CODE_SLP;
            ipc_pkg::S_ISO: c = ipc_pkg::CODE_ISO;
            ipc_pkg::S_CFG: c = ipc_pkg::CODE_CFG;
            default: c = ipc_pkg::CODE_WFK;
        endcase
        return c;
    endfunction

    logic addr_ok;
    logic wr_index;
    logic wr_data;
    logic rd_port_hit;
    logic rd_rise;
    logic rd_fall;
    logic awake;
    logic [3:0] h_slot;
    logic [3:0] l_slot;
    logic [7:0] key_step;
    logic h_srst;
    logic wake_hit;
    logic card_sel_hit;
    logic iso_rd;
    logic m_wr;

    // upper address bits and AEN are decoded outside the chip
    assign addr_ok = !I_HOST_ADDR_QUALIFIER_N; // [R1]
    assign wr_index = addr_ok && I_HOST_WR
        && I_HOST_ADDR == ipc_pkg::HOST_INDEX_ADDR; // [R2]
    assign wr_data = addr_ok && I_HOST_WR
        && I_HOST_ADDR == ipc_pkg::HOST_WDATA_ADDR; // [R2]
    // rd_addr bit 7 low would fall below 0203h, so the port stays off
    assign rd_port_hit = addr_ok && st.rd_addr[7]
        && I_HOST_ADDR[11:10] == 2'b00 && I_HOST_ADDR[1:0] == 2'b11
        && I_HOST_ADDR[9:2] == st.rd_addr; // [R3] [R24]
    assign rd_rise = I_HOST_RD && !st.rd_prev && rd_port_hit;
    assign rd_fall = !I_HOST_RD && st.rd_prev;
    assign awake = st.fsm != ipc_pkg::S_WFK; // [R5]
    assign h_slot = cfg_slot(st.index);
    assign l_slot = cfg_slot(I_LOC_ADDR[7:0]);
    // public key generator: shift right, feedback of the two low bits
    assign key_step = {st.key_exp[0] ^ st.key_exp[1], st.key_exp[7:1]};
    assign h_srst = wr_data && awake && st.index == ipc_pkg::IDX_CTRL
        && I_HOST_DATA[ipc_pkg::CTRL_SRST];
    assign wake_hit = wr_data && awake && st.index == ipc_pkg::IDX_WAKE;
    assign card_sel_hit = wr_data && st.index == ipc_pkg::IDX_CARD_SEL
        && (st.fsm == ipc_pkg::S_ISO || st.fsm == ipc_pkg::S_CFG);
    assign iso_rd = rd_rise && st.fsm == ipc_pkg::S_ISO
        && st.index == ipc_pkg::IDX_ISOLATE;
    assign m_wr = I_LOC_WR && I_LOC_ADDR == ipc_pkg::LOC_MASTER;

    always_comb begin
        next_st = st;
        next_st.rd_prev = I_HOST_RD;
        // every card takes the index write, in any state
        if (wr_index) begin
            next_st.index = I_HOST_DATA; // [R4] [R23]
        end
        // key matching only while waiting for it
        if (wr_index && st.fsm == ipc_pkg::S_WFK) begin
            if (I_HOST_DATA == st.key_exp) begin
                next_st.key_exp = key_step;
                next_st.key_cnt = st.key_cnt + 5'h01;
                if (st.key_cnt == ipc_pkg::KEY_LAST) begin
                    next_st.fsm = ipc_pkg::S_SLP; // [R6]
                    next_st.key_exp = ipc_pkg::KEY_SEED;
                    next_st.key_cnt = 5'h00;
                end
            end else if (I_HOST_DATA == ipc_pkg::KEY_SEED) begin
                // a fresh seed byte starts a new attempt at once
                next_st.key_exp = {ipc_pkg::KEY_SEED[0]
                    ^ ipc_pkg::KEY_SEED[1], ipc_pkg::KEY_SEED[7:1]};
                next_st.key_cnt = 5'h01; // [R25]
            end else begin
                next_st.key_exp = ipc_pkg::KEY_SEED; // [R25]
                next_st.key_cnt = 5'h00;
            end
        end

        // firmware writes the master back: ones clear the flags
        if (m_wr) begin
            next_st.ie = I_LOC_WDATA[ipc_pkg::M_IE];
            next_st.iso_bit = I_LOC_WDATA[ipc_pkg::M_ISO_BIT]; // [R10]
            if (I_LOC_WDATA[ipc_pkg::M_IP]) begin
                next_st.ip = 1'b0; // [R17]
            end
            if (I_LOC_WDATA[ipc_pkg::M_EV_SRST]) begin
                next_st.ev_srst = 1'b0; // [R17]
            end
            if (I_LOC_WDATA[ipc_pkg::M_EV_WAKE]) begin
                next_st.ev_wake = 1'b0; // [R17]
            end
            if (I_LOC_WDATA[ipc_pkg::M_EV_ISO]) begin
                next_st.ev_iso = 1'b0; // [R17]
            end
        end
        if (I_LOC_WR && I_LOC_ADDR == ipc_pkg::LOC_RESOURCE) begin
            next_st.res_data = I_LOC_WDATA;
            next_st.res_ready = 1'b1;
        end
        if (I_LOC_WR && I_LOC_ADDR[8] && l_slot[3]) begin
            next_st.cfg[l_slot[2:0]] = I_LOC_WDATA;
        end

        // host register writes through the data port
        if (wr_data && awake) begin
            case (st.index)
                ipc_pkg::IDX_RD_ADDR: begin
                    if (st.fsm != ipc_pkg::S_CFG) begin
                        next_st.rd_addr = I_HOST_DATA;
                    end
                end
                ipc_pkg::IDX_CTRL: begin
                    if (I_HOST_DATA[ipc_pkg::CTRL_CARD_SEL_CLR]) begin
                        next_st.card_sel = 8'h00;
                    end
                    if (I_HOST_DATA[ipc_pkg::CTRL_WFK]) begin
                        next_st.fsm = ipc_pkg::S_WFK; // [R5]
                    end
                end
                default: begin
                    if (h_slot[3] && st.fsm == ipc_pkg::S_CFG) begin
                        next_st.cfg[h_slot[2:0]] = I_HOST_DATA; // [R13]
                    end
                end
            endcase
        end
        if (h_srst) begin
            next_st.cfg = '0; // [R15]
            next_st.ev_srst = 1'b1; // [R15]
            // pending is set after the master clear, so an event wins
            next_st.ip = 1'b1; // [R16]
        end

        if (wake_hit) begin
            if (I_HOST_DATA == 8'h00) begin
                if (st.fsm == ipc_pkg::S_SLP && st.card_sel == 8'h00) begin
                    next_st.fsm = ipc_pkg::S_ISO; // [R7] [R18]
                    next_st.iso_second = 1'b0;
                    next_st.ev_wake = 1'b1;
                    next_st.ip = 1'b1; // [R16]
                end else if (st.fsm == ipc_pkg::S_CFG) begin
                    next_st.fsm = ipc_pkg::S_SLP; // [R12]
                end
            end else if (I_HOST_DATA == st.card_sel) begin
                next_st.fsm = ipc_pkg::S_CFG; // [R13]
                next_st.ev_wake = 1'b1;
                next_st.ip = 1'b1; // [R16]
            end else begin
                next_st.fsm = ipc_pkg::S_SLP; // [R13]
            end
        end
        if (card_sel_hit) begin
            next_st.card_sel = I_HOST_DATA;
            next_st.fsm = ipc_pkg::S_CFG; // [R11]
            if (I_HOST_DATA != 8'h00) begin
                next_st.ev_wake = 1'b1; // [R26]
                next_st.ip = 1'b1; // [R16]
            end
        end

        // host reads; data is presented from the cycle after the edge
        if (rd_rise && awake) begin
            next_st.hoe = 1'b1;
            next_st.hrdata = 8'h00;
            case (st.index)
                ipc_pkg::IDX_ISOLATE: begin
                    next_st.hoe = iso_rd && st.iso_bit; // [R19]
                    next_st.hrdata = st.iso_second ? ipc_pkg::ISO_SECOND
                        : ipc_pkg::ISO_FIRST; // [R19]
                end
                ipc_pkg::IDX_RESOURCE: begin
                    next_st.hrdata = st.res_data;
                    next_st.res_ready = 1'b0;
                end
                ipc_pkg::IDX_STATUS: begin
                    next_st.hrdata = {7'h00, st.res_ready};
                end
                ipc_pkg::IDX_CARD_SEL: begin
                    next_st.hrdata = st.card_sel;
                end
                ipc_pkg::IDX_LDN: begin
                    next_st.hrdata = 8'h00;
                end
                default: begin
                    next_st.hoe = h_slot[3];
                    next_st.hrdata = st.cfg[h_slot[2:0]];
                end
            endcase
            if (st.fsm != ipc_pkg::S_CFG && !iso_rd) begin
                next_st.hoe = 1'b0;
            end
            next_st.rd_iso = iso_rd;
        end
        // a quiet card watches what the others put on the low pair
        if (st.rd_iso && I_HOST_RD) begin
            next_st.low_pair = I_HOST_DATA[1:0]; // [R20]
        end
        if (rd_fall) begin
            next_st.hoe = 1'b0;
            next_st.rd_iso = 1'b0;
        end
        if (rd_fall && st.rd_iso && st.fsm == ipc_pkg::S_ISO) begin
            next_st.iso_second = !st.iso_second;
            if (st.iso_second) begin
                next_st.ev_iso = 1'b1; // [R21]
                next_st.ip = 1'b1; // [R16]
            end
            if (!st.iso_bit && st.low_pair == (st.iso_second
                ? ipc_pkg::ISO_SECOND[1:0] : ipc_pkg::ISO_FIRST[1:0])) begin
                next_st.fsm = ipc_pkg::S_SLP; // [R9] [R20]
            end
        end

        if (I_LOC_RD) begin
            case (I_LOC_ADDR)
                ipc_pkg::LOC_MASTER: begin
                    next_st.lrdata = {st.ie, st.ip, st.ev_srst, st.ev_wake,
                        st.ev_iso, st.iso_bit, state_code(st.fsm)};
                end
                ipc_pkg::LOC_RESOURCE: next_st.lrdata = st.res_data;
                ipc_pkg::LOC_STATUS: next_st.lrdata = {7'h00, st.res_ready};
                ipc_pkg::LOC_CARD_SEL: next_st.lrdata = st.card_sel;
                default: begin
                    next_st.lrdata = (I_LOC_ADDR[8] && l_slot[3])
                        ? st.cfg[l_slot[2:0]] : 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st <= '0;
            st.fsm <= ipc_pkg::S_WFK; // [R5]
            st.key_exp <= ipc_pkg::KEY_SEED;
        end else if (I_CLK_EN) begin
            st <= next_st;
        end
    end

    // identity never stored here, only the single bit in flight
    assign O_HOST_DATA = st.hrdata; // [R8]
    assign O_HOST_DATA_OE = st.hoe;
    assign O_LOC_RDATA = st.lrdata;
    assign O_LOC_IRQ = st.ie && st.ip; // [R16]
    assign O_PNP_STATE = state_code(st.fsm); // [R18]
    // resources stay live whatever the state, wait-for-key included
    assign O_ACTIVATE = st.cfg[0]; // [R14]
    assign O_IO0_BASE = {st.cfg[1], st.cfg[2]}; // [R14]
    assign O_IO1_BASE = {st.cfg[3], st.cfg[4]};
    assign O_IRQ_LEVEL = st.cfg[5];
    assign O_DMA0 = st.cfg[6];
    assign O_DMA1 = st.cfg[7];

    property p_key_exit;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (st.fsm == ipc_pkg::S_SLP && $past(st.fsm) == ipc_pkg::S_WFK)
            |-> $past(st.key_cnt) == ipc_pkg::KEY_LAST;
    endproperty
    a_key_exit: assert property (p_key_exit) // [R6]
        else $error("left wait-for-key without full key");

    property p_wfk_silent;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && rd_rise && st.fsm == ipc_pkg::S_WFK) |=> !st.hoe;
    endproperty
    a_wfk_silent: assert property (p_wfk_silent) // [R5]
        else $error("bus driven in wait-for-key");

    property p_srst;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && h_srst) |=> st.ev_srst && st.ip && st.cfg == '0;
    endproperty
    a_srst: assert property (p_srst) // [R15]
        else $error("software reset not taken");

    property p_wake_iso;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && wake_hit && I_HOST_DATA == 8'h00 && !card_sel_hit
            && st.fsm == ipc_pkg::S_SLP && st.card_sel == 8'h00)
            |=> O_PNP_STATE == ipc_pkg::CODE_ISO && st.ev_wake;
    endproperty
    a_wake_iso: assert property (p_wake_iso) // [R7]
        else $error("wake zero did not start isolation");

    property p_wake_cfg_sleep;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && wake_hit && I_HOST_DATA == 8'h00
            && st.fsm == ipc_pkg::S_CFG) |=> st.fsm == ipc_pkg::S_SLP;
    endproperty
    a_wake_cfg_sleep: assert property (p_wake_cfg_sleep) // [R12]
        else $error("configured card did not sleep");

    property p_card_sel_assign;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && card_sel_hit && st.fsm == ipc_pkg::S_ISO)
            |=> st.fsm == ipc_pkg::S_CFG && st.card_sel == $past(I_HOST_DATA);
    endproperty
    a_card_sel_assign: assert property (p_card_sel_assign) // [R11]
        else $error("card number not assigned");

    property p_iso_drive;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && iso_rd && st.iso_bit && !rd_fall)
            |=> O_HOST_DATA_OE && (O_HOST_DATA == ipc_pkg::ISO_FIRST
                || O_HOST_DATA == ipc_pkg::ISO_SECOND);
    endproperty
    a_iso_drive: assert property (p_iso_drive) // [R19]
        else $error("no active isolation answer");

    property p_iso_event;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        $rose(st.ev_iso) |-> st.ip && $past(st.iso_second)
            && $past(st.rd_iso);
    endproperty
    a_iso_event: assert property (p_iso_event) // [R21]
        else $error("isolation event out of place");

    property p_master_clear;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && m_wr && I_LOC_WDATA[ipc_pkg::M_EV_SRST] && !h_srst)
            |=> !st.ev_srst;
    endproperty
    a_master_clear: assert property (p_master_clear) // [R17]
        else $error("software reset event not cleared");

    property p_irq;
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (I_CLK_EN && st.ie && $rose(st.ev_wake)) |-> O_LOC_IRQ;
    endproperty
    a_irq: assert property (p_irq) // [R16]
        else $error("enabled event gave no interrupt");
endmodule
`default_nettype wire

// File: hdl/ipc_pkg.sv
// Purpose: constants and types of the plug-and-play configuration port
// Assumes: host and local strobes are synchronous to the block clock
// Notes: local addresses are the low nine bits of the local i/o space
// Behaviour
// [R1] Decode twelve host address lines, valid only while qualifier is low.
// [R2] Write-only index port at 0279h, write-only data port at 0A79h.
// [R3] Read-only data port relocatable, four apart, 0203h up to 03FFh.
// [R4] Index space of 256 locations; index writes reach every card.
// [R5] Reset or host command puts card in wait-for-key; nothing reachable.
// [R6] Host sends 32-value key; card detects it and goes to sleep.
// [R7] Wake with number zero moves unconfigured sleeping cards to isolation.
// [R8] Card identity lives in firmware only; hardware holds none of it.
// [R9] Card losing isolation returns to sleep by itself.
// [R10] Firmware feeds identity and checksum one bit at a time.
// [R11] Assigning a card number moves isolated card to configuration.
// [R12] Wake zero sends configured card to sleep, unconfigured to isolation.
// [R13] Wake with matching card number alone enters configuration.
// [R14] In wait-for-key allocated resources stay decoded and routed.
// [R15] Control bit 0 written one resets config registers, flags event.
// [R16] Local interrupt requested while enable and pending are both set.
// [R17] Writing master register back clears pending and set event bits.
// [R18] Master shows two-bit state; wake zero moves 01 to 10.
// [R19] Isolation bit one: drive active answer on next read pair.
// [R20] Isolation bit zero: watch low data pair, sleep if another answered.
// [R21] Each isolation read pair in state 10 flags an event.
// [R22] Host leaves at least 250 us between isolation read pairs.
// [R23] Data ports reach the register last selected by the index port.
// [R24] Read port matches bits 9:2, needs bits 1:0 high, 11:10 low.
// [R25] Key is the public 32-value sequence; mismatch restarts matching.
// [R26] Nonzero card number write flags wake-match so firmware loads data.
package ipc_pkg;
    localparam logic [11:0] HOST_INDEX_ADDR = 12'h279;
    localparam logic [11:0] HOST_WDATA_ADDR = 12'ha79;
    localparam logic [7:0] IDX_RD_ADDR = 8'h00;
    localparam logic [7:0] IDX_ISOLATE = 8'h01;
    localparam logic [7:0] IDX_CTRL = 8'h02;
    localparam logic [7:0] IDX_WAKE = 8'h03;
    localparam logic [7:0] IDX_RESOURCE = 8'h04;
    localparam logic [7:0] IDX_STATUS = 8'h05;
    localparam logic [7:0] IDX_CARD_SEL = 8'h06;
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam int CFG_N = 8;
    // activate, io0 hi/lo, io1 hi/lo, irq0, dma0, dma1
    localparam logic [7:0][7:0] CFG_IDX = {8'h75, 8'h74, 8'h70, 8'h63,
                                           8'h62, 8'h61, 8'h60, 8'h30};
    localparam logic [8:0] LOC_MASTER = 9'h102;
    localparam logic [8:0] LOC_RESOURCE = 9'h104;
    localparam logic [8:0] LOC_STATUS = 9'h105;
    localparam logic [8:0] LOC_CARD_SEL = 9'h106;
    localparam int CTRL_SRST = 0;
    localparam int CTRL_WFK = 1;
    localparam int CTRL_CARD_SEL_CLR = 2;
    localparam int M_IE = 7;
    localparam int M_IP = 6;
    localparam int M_EV_SRST = 5;
    localparam int M_EV_WAKE = 4;
    localparam int M_EV_ISO = 3;
    localparam int M_ISO_BIT = 2;
    localparam logic [7:0] KEY_SEED = 8'h6a;
    localparam logic [4:0] KEY_LAST = 5'h1f;
    localparam logic [7:0] ISO_FIRST = 8'h55;
    localparam logic [7:0] ISO_SECOND = 8'haa;
    localparam logic [1:0] CODE_WFK = 2'h0;
    localparam logic [1:0] CODE_SLP = 2'h1;
    localparam logic [1:0] CODE_ISO = 2'h2;
    localparam logic [1:0] CODE_CFG = 2'h3;
    localparam int ISO_GAP_US = 250;
    typedef enum logic [3:0] {
        S_WFK = 4'h1,
        S_SLP = 4'h2,
        S_ISO = 4'h4,
        S_CFG = 4'h8
    } ipc_fsm_e;
endpackage

// File: testbench/ipc_host.sv
// Purpose: isa host model for the configuration port
// Assumes: shares the card clock, drives 1 ns after each edge
// Notes: rival mimics another card answering isolation reads
`timescale 1ns/10ps
`default_nettype none
module ipc_host (
    input wire logic i_clk,
    input wire logic [7:0] i_card_data,
    input wire logic i_card_oe,
    output logic [11:0] o_addr,
    output logic o_qual_n,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_data
);
    logic [7:0] wdata = 8'h00;
    logic [7:0] other = 8'h00;
    logic rival = 1'b0;
    logic qual_hi = 1'b0;
    initial begin
        o_addr = 12'h000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    assign o_qual_n = qual_hi;
    // released bus shows the inverse, never a stale copy
    assign o_data = o_wr ? wdata : i_card_oe ? i_card_data :
        rival ? other : ~wdata;
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge i_clk);
        #1;
        o_addr = a;
        wdata = v;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v,
            output logic e);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        v = i_card_data;
        e = i_card_oe;
        o_rd = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    // a stray 6a then a wrong value first, so matching must restart
    task automatic key();
        logic [7:0] k;
        k = 8'h6a;
        wr(ipc_pkg::HOST_INDEX_ADDR, 8'h6a);
        wr(ipc_pkg::HOST_INDEX_ADDR, 8'h00);
        for (int n = 0; n < 32; n++) begin
            wr(ipc_pkg::HOST_INDEX_ADDR, k);
            k = {k[0] ^ k[1], k[7:1]};
        end
    endtask
    task automatic pair(input logic [11:0] a, output logic [15:0] v,
            output logic [1:0] e);
        repeat (2500) @(posedge i_clk);
        other = 8'h01;
        rd(a, v[15:8], e[1]);
        other = 8'h02;
        rd(a, v[7:0], e[0]);
    endtask
endmodule
`default_nettype wire

// File: testbench/ipc_top_tb.sv
// Purpose: self-checking bench for the configuration port
// Assumes: host model shares the clock; local strobes come from here
// Notes: read port sits at 203h once 80h is written to its index
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, v) n_checks++; if ((v) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", nm, e, v); end
module ipc_top_tb;
    localparam logic [11:0] RDP = 12'h203;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic hq_n, hw, hr, oe, irq, g;
    logic lw = 1'b0;
    logic lr = 1'b0;
    logic [8:0] la = 9'h000;
    logic [11:0] ha;
    logic [7:0] hd, od, lq, act, irl, d0, d1, m, d;
    logic [7:0] lwd = 8'h00;
    logic [15:0] io0, io1, pd;
    logic [1:0] st, po;
    int n_errors = 0;
    int n_checks = 0;
    always #50 clk = ~clk;
    ipc_top ipc_top_i (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CLK_EN(ce),
        .I_HOST_ADDR(ha), .I_HOST_ADDR_QUALIFIER_N(hq_n), .I_HOST_WR(hw),
        .I_HOST_RD(hr), .I_HOST_DATA(hd), .O_HOST_DATA(od),
        .O_HOST_DATA_OE(oe), .I_LOC_ADDR(la), .I_LOC_WR(lw), .I_LOC_RD(lr),
        .I_LOC_WDATA(lwd), .O_LOC_RDATA(lq), .O_LOC_IRQ(irq),
        .O_PNP_STATE(st), .O_ACTIVATE(act), .O_IO0_BASE(io0),
        .O_IO1_BASE(io1), .O_IRQ_LEVEL(irl), .O_DMA0(d0), .O_DMA1(d1));
    ipc_host ipc_host_i (.i_clk(clk), .i_card_data(od), .i_card_oe(oe),
        .o_addr(ha), .o_qual_n(hq_n), .o_wr(hw), .o_rd(hr), .o_data(hd));
    task automatic loc(input logic w, input logic [8:0] a,
            input logic [7:0] v);
        @(posedge clk);
        #1;
        la = a;
        lwd = v;
        lw = w;
        lr = !w;
        @(posedge clk);
        #1;
        lw = 1'b0;
        lr = 1'b0;
        @(posedge clk);
        #1;
        m = lq;
    endtask
    task automatic hwr(input logic [7:0] i, input logic [7:0] v);
        ipc_host_i.wr(ipc_pkg::HOST_INDEX_ADDR, i);
        ipc_host_i.wr(ipc_pkg::HOST_WDATA_ADDR, v);
    endtask
    task automatic hrd(input logic [7:0] i);
        ipc_host_i.wr(ipc_pkg::HOST_INDEX_ADDR, i);
        ipc_host_i.rd(RDP, d, g);
    endtask
    task automatic t_key();
        `CHK("state", 2'h0, st)
        hrd(ipc_pkg::IDX_CARD_SEL);
        `CHK("read oe", 1'b0, g)
        ipc_host_i.qual_hi = 1'b1;
        ipc_host_i.key();
        ipc_host_i.qual_hi = 1'b0;
        `CHK("state", 2'h0, st)
        ipc_host_i.key();
        `CHK("state", 2'h1, st)
    endtask
    task automatic t_iso();
        hwr(ipc_pkg::IDX_WAKE, 8'h00);
        `CHK("state", 2'h2, st)
        hwr(ipc_pkg::IDX_RD_ADDR, 8'h80);
        loc(1'b1, ipc_pkg::LOC_MASTER, 8'h80);
        `CHK("irq", 1'b1, irq)
        loc(1'b0, ipc_pkg::LOC_MASTER, 8'h00);
        `CHK("master", 8'hd2, m)
        loc(1'b1, ipc_pkg::LOC_MASTER, m | 8'h04);
        `CHK("irq", 1'b0, irq)
        ipc_host_i.wr(ipc_pkg::HOST_INDEX_ADDR, ipc_pkg::IDX_ISOLATE);
        ipc_host_i.rd(12'h603, d, g);
        `CHK("read oe", 1'b0, g)
        ipc_host_i.pair(RDP, pd, po);
        `CHK("iso data", 16'h55aa, pd)
        `CHK("iso oe", 2'h3, po)
        loc(1'b0, ipc_pkg::LOC_MASTER, 8'h00);
        `CHK("master", 8'hce, m)
        loc(1'b1, ipc_pkg::LOC_MASTER, m & 8'hfb);
        ipc_host_i.rival = 1'b1;
        ipc_host_i.pair(RDP, pd, po);
        ipc_host_i.rival = 1'b0;
        `CHK("iso oe", 2'h0, po)
        `CHK("state", 2'h1, st)
    endtask
    task automatic t_cfg();
        hwr(ipc_pkg::IDX_WAKE, 8'h00);
        `CHK("state", 2'h2, st)
        loc(1'b1, ipc_pkg::LOC_MASTER, 8'hd6);
        hwr(ipc_pkg::IDX_CARD_SEL, 8'h01);
        `CHK("state", 2'h3, st)
        loc(1'b0, ipc_pkg::LOC_MASTER, 8'h00);
        `CHK("wake event", 1'b1, m[ipc_pkg::M_EV_WAKE])
        loc(1'b0, ipc_pkg::LOC_CARD_SEL, 8'h00);
        `CHK("card number", 8'h01, m)
        hwr(8'h60, 8'h12);
        hwr(8'h61, 8'h34);
        `CHK("io0", 16'h1234, io0)
        hwr(8'h30, 8'h01);
        hwr(8'h62, 8'h56);
        hwr(8'h63, 8'h78);
        hwr(8'h70, 8'h05);
        loc(1'b1, 9'h174, 8'h03);
        loc(1'b1, 9'h175, 8'h06);
        loc(1'b0, 9'h170, 8'h00);
        `CHK("irq level read", 8'h05, m)
        `CHK("activate", 8'h01, act)
        `CHK("io1", 16'h5678, io1)
        `CHK("irq level", 8'h05, irl)
        `CHK("dma0", 8'h03, d0)
        `CHK("dma1", 8'h06, d1)
        hrd(ipc_pkg::IDX_CARD_SEL);
        `CHK("card number read", 8'h01, d)
        hwr(ipc_pkg::IDX_WAKE, 8'h00);
        `CHK("state", 2'h1, st)
        hwr(ipc_pkg::IDX_WAKE, 8'h01);
        `CHK("state", 2'h3, st)
        hwr(ipc_pkg::IDX_CTRL, 8'h01);
        `CHK("io0", 16'h0000, io0)
        loc(1'b0, ipc_pkg::LOC_MASTER, 8'h00);
        `CHK("srst event", 1'b1, m[ipc_pkg::M_EV_SRST])
        `CHK("dma1", 8'h00, d1)
        // frozen card must ignore a config write
        ce = 1'b0;
        hwr(8'h60, 8'h55);
        ce = 1'b1;
        `CHK("io0", 16'h0000, io0)
        hwr(8'h60, 8'hab);
        hwr(ipc_pkg::IDX_CTRL, 8'h02);
        `CHK("state", 2'h0, st)
        hwr(8'h60, 8'hcd);
        `CHK("io0", 16'hab00, io0)
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_key();
        t_iso();
        t_cfg();
        summarize();
    end
    // whole run is under 10000 cycles; allow three times that
    initial begin
        #3000000;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
